// ===== shared/mpfc_pkg.sv
// Constants for the miscellaneous pin function control block.
// Assumes a 50 MHz CPU-side clock and synchronous register strobes.
package mpfc_pkg;
  localparam logic [7:0] ADDR_SENSE_NMI = 8'h20;
  localparam logic [7:0] ADDR_CLKOUT_BEEP = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h61;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] RESERVED_MASK = 8'hF3;
  localparam int G1_SENSE_HI = 7;
  localparam int G1_SENSE_LO = 6;
  localparam int G2_SENSE_HI = 5;
  localparam int G2_SENSE_LO = 4;
  localparam int NMI_EDGE_BIT = 1;
  localparam int NMI_ENABLE_BIT = 0;
  localparam int AUX_CLKOUT_BIT = 7;
  localparam int MAIN_CLKOUT_BIT = 6;
  localparam int BEEP_HI_BIT = 5;
  localparam int BEEP_LO_BIT = 4;
  localparam int SS_SOURCE_BIT = 1;
  localparam int SS_INTERNAL_BIT = 0;
  localparam logic [1:0] PRIORITY_LEVEL3 = 2'h3;
  localparam int CLK_HZ = 50000000;
  localparam int BEEP2K_HZ = 2000;
  localparam logic [15:0] BEEP2K_HALF = 16'((CLK_HZ / BEEP2K_HZ) / 2);
  localparam logic [15:0] BEEP1K_HALF = 16'((CLK_HZ / (BEEP2K_HZ / 2)) / 2);
  localparam logic [15:0] BEEP500_HALF = 16'((CLK_HZ / (BEEP2K_HZ / 4)) / 2);
  localparam int IRQ_LINES = 5;
  localparam logic [5:0] IRQ_NONE = 6'h00;
  typedef enum logic [1:0] {
    MPFC_FALL_LOW = 2'b00,
    MPFC_FALL = 2'b01,
    MPFC_RISE = 2'b10,
    MPFC_BOTH = 2'b11
  } mpfc_sense_t;
endpackage : mpfc_pkg

// ===== hdl/mpfc_edge_detect.sv
// One synchronised interrupt pin with selectable edge or level detection.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mpfc_edge_detect (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic pinIn,
  input wire logic [1:0] sense,
  output logic detected
);
  logic sync1_reg, sync1_next, sync2_reg, sync2_next, prev_reg, prev_next, ev_reg, ev_next;
  always_comb begin
    sync1_next = pinIn;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    unique case (mpfc_pkg::mpfc_sense_t'(sense))
      mpfc_pkg::MPFC_FALL_LOW: ev_next = ~sync2_reg;
      mpfc_pkg::MPFC_FALL: ev_next = prev_reg & ~sync2_reg;
      mpfc_pkg::MPFC_RISE: ev_next = ~prev_reg & sync2_reg;
      mpfc_pkg::MPFC_BOTH: ev_next = prev_reg ^ sync2_reg;
    endcase
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
      ev_reg <= 1'b0;
    end else if (clkEn) begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      ev_reg <= ev_next;
    end
  end
  assign detected = ev_reg;
endmodule : mpfc_edge_detect
`default_nettype wire

// ===== hdl/mpfc_divider.sv
// Square wave generator toggling every halfPeriod cycles while enabled.
// Assumes halfPeriod is at least one.
`timescale 1ns/1ps
`default_nettype none
module mpfc_divider (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic enable,
  input wire logic [15:0] halfPeriod,
  output logic wave
);
  logic [15:0] cnt_reg, cnt_next;
  logic wave_reg, wave_next;
  always_comb begin
    cnt_next = cnt_reg;
    wave_next = wave_reg;
    if (!enable) begin
      cnt_next = 16'h0000;
      wave_next = 1'b0;
    end else if (cnt_reg + 16'h0001 >= halfPeriod) begin
      cnt_next = 16'h0000;
      wave_next = ~wave_reg;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
      wave_reg <= 1'b0;
    end else if (clkEn) begin
      cnt_reg <= cnt_next;
      wave_reg <= wave_next;
    end
  end
  assign wave = wave_reg;
endmodule : mpfc_divider
`default_nettype wire

// ===== hdl/mpfc_misc_pin_function_control.sv
// Miscellaneous pin function control: interrupt sensitivity, NMI, clock-out, beep, SS source.
// Assumes synchronous register strobes and slow enables for the oscillator inputs.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mpfc_misc_pin_function_control (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [1:0] interruptPriorityLevel,
  input wire logic haltMode,
  input wire logic auxOscHalf,
  input wire logic mainOscHalf,
  input wire logic extIrqPortaLowPin,
  input wire logic extIrqPortaHighPin,
  input wire logic extIrqPortbPin,
  input wire logic extIrqPortcPin,
  input wire logic extIrqPortdPin,
  input wire logic nmiPin,
  input wire logic slaveSelectPinIn,
  output logic [4:0] extIrqEvent,
  output logic nmiEvent,
  output logic spiSlaveSelect,
  output logic slaveSelectPinFree,
  output logic auxClockPinOut,
  output logic auxClockPinOe,
  output logic beepClockPinOut,
  output logic beepClockPinOe,
  output logic irq
);
  logic [7:0] senseNmi_reg, senseNmi_next;
  logic [7:0] clkBeep_reg, clkBeep_next;
  logic [5:0] status_reg, status_next;
  logic [5:0] mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [4:0] ext_reg, ext_next;
  logic nmiEv_reg, nmiEv_next;
  logic ssel_reg, ssel_next, ssFree_reg, ssFree_next;
  logic auxOut_reg, auxOut_next, auxOe_reg, auxOe_next;
  logic beepOut_reg, beepOut_next, beepOe_reg, beepOe_next;
  logic irq_reg, irq_next;
  logic [4:0] extRaw;
  logic nmiRaw;
  logic [1:0] nmiSense;
  logic [1:0] grp1, grp2;
  logic [4:0] pins;
  logic [2:0] beepSel;
  logic [15:0] beepHalf;
  logic beepOn, beepWave;
  logic [5:0] events;
  logic lvl3;

  assign grp1 = senseNmi_reg[mpfc_pkg::G1_SENSE_HI:mpfc_pkg::G1_SENSE_LO];
  assign grp2 = senseNmi_reg[mpfc_pkg::G2_SENSE_HI:mpfc_pkg::G2_SENSE_LO];
  assign pins = {extIrqPortdPin, extIrqPortcPin, extIrqPortbPin, extIrqPortaHighPin,
    extIrqPortaLowPin};
  assign nmiSense = senseNmi_reg[mpfc_pkg::NMI_EDGE_BIT] ? 2'h2 : 2'h1;

  genvar gi;
  generate
    for (gi = 0; gi < mpfc_pkg::IRQ_LINES; gi++) begin : g_ext
      mpfc_edge_detect u_det (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .pinIn(pins[gi]),
        .sense((gi == 1 || gi == 3) ? grp2 : grp1),
        .detected(extRaw[gi])
      );
    end
  endgenerate

  mpfc_edge_detect u_nmi (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .pinIn(nmiPin),
    .sense(nmiSense),
    .detected(nmiRaw)
  );

  assign beepSel = clkBeep_reg[mpfc_pkg::MAIN_CLKOUT_BIT:mpfc_pkg::BEEP_LO_BIT];
  assign beepOn = (beepSel[1:0] != 2'h0) && !haltMode;
  always_comb begin
    unique case (beepSel[1:0])
      2'h1: beepHalf = mpfc_pkg::BEEP2K_HALF;
      2'h2: beepHalf = mpfc_pkg::BEEP1K_HALF;
      default: beepHalf = mpfc_pkg::BEEP500_HALF;
    endcase
  end

  mpfc_divider u_beep (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .enable(beepOn),
    .halfPeriod(beepHalf),
    .wave(beepWave)
  );

  assign lvl3 = (interruptPriorityLevel == mpfc_pkg::PRIORITY_LEVEL3);
  assign events = {nmiRaw & senseNmi_reg[mpfc_pkg::NMI_ENABLE_BIT], extRaw};

  always_comb begin
    senseNmi_next = senseNmi_reg;
    clkBeep_next = clkBeep_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rdata_next = mpfc_pkg::RESET_VALUE;
    if (regWr) begin
      unique case (regAddr)
        mpfc_pkg::ADDR_SENSE_NMI: begin
          if (lvl3) begin
            senseNmi_next[7:4] = regWdata[7:4];
          end
          if (!senseNmi_reg[mpfc_pkg::NMI_ENABLE_BIT]) begin
            senseNmi_next[mpfc_pkg::NMI_EDGE_BIT] = regWdata[mpfc_pkg::NMI_EDGE_BIT];
          end
          senseNmi_next[mpfc_pkg::NMI_ENABLE_BIT] = regWdata[mpfc_pkg::NMI_ENABLE_BIT];
        end
        mpfc_pkg::ADDR_CLKOUT_BEEP: clkBeep_next = regWdata & mpfc_pkg::RESERVED_MASK;
        mpfc_pkg::ADDR_IRQ_STATUS: status_next = status_reg & ~regWdata[5:0];
        mpfc_pkg::ADDR_IRQ_MASK: mask_next = regWdata[5:0];
        default: ;
      endcase
    end
    status_next = status_next | events;
    if (regRd) begin
      unique case (regAddr)
        mpfc_pkg::ADDR_SENSE_NMI: rdata_next = senseNmi_reg & mpfc_pkg::RESERVED_MASK;
        mpfc_pkg::ADDR_CLKOUT_BEEP: rdata_next = clkBeep_reg & mpfc_pkg::RESERVED_MASK;
        mpfc_pkg::ADDR_IRQ_STATUS: rdata_next = {2'h0, status_reg};
        mpfc_pkg::ADDR_IRQ_MASK: rdata_next = {2'h0, mask_reg};
        default: rdata_next = mpfc_pkg::RESET_VALUE;
      endcase
    end
    irq_next = (status_next & mask_next) != mpfc_pkg::IRQ_NONE;
    ext_next = extRaw;
    nmiEv_next = events[5];
    ssel_next = clkBeep_reg[mpfc_pkg::SS_SOURCE_BIT] ?
      clkBeep_reg[mpfc_pkg::SS_INTERNAL_BIT] : slaveSelectPinIn;
    ssFree_next = clkBeep_reg[mpfc_pkg::SS_SOURCE_BIT];
    auxOe_next = clkBeep_reg[mpfc_pkg::AUX_CLKOUT_BIT] && !haltMode;
    auxOut_next = auxOe_next & auxOscHalf;
    beepOe_next = (beepSel != 3'h0) && !haltMode;
    if (beepSel == 3'h4) begin
      beepOut_next = beepOe_next & mainOscHalf;
    end else begin
      beepOut_next = beepOe_next & beepWave;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      senseNmi_reg <= mpfc_pkg::RESET_VALUE;
      clkBeep_reg <= mpfc_pkg::RESET_VALUE;
      status_reg <= 6'h00;
      mask_reg <= 6'h00;
      rdata_reg <= 8'h00;
      ext_reg <= 5'h00;
      nmiEv_reg <= 1'b0;
      ssel_reg <= 1'b1;
      ssFree_reg <= 1'b0;
      auxOut_reg <= 1'b0;
      auxOe_reg <= 1'b0;
      beepOut_reg <= 1'b0;
      beepOe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (clkEn) begin
      senseNmi_reg <= senseNmi_next;
      clkBeep_reg <= clkBeep_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      ext_reg <= ext_next;
      nmiEv_reg <= nmiEv_next;
      ssel_reg <= ssel_next;
      ssFree_reg <= ssFree_next;
      auxOut_reg <= auxOut_next;
      auxOe_reg <= auxOe_next;
      beepOut_reg <= beepOut_next;
      beepOe_reg <= beepOe_next;
      irq_reg <= irq_next;
    end
  end

  assign regRdata = rdata_reg;
  assign extIrqEvent = ext_reg;
  assign nmiEvent = nmiEv_reg;
  assign spiSlaveSelect = ssel_reg;
  assign slaveSelectPinFree = ssFree_reg;
  assign auxClockPinOut = auxOut_reg;
  assign auxClockPinOe = auxOe_reg;
  assign beepClockPinOut = beepOut_reg;
  assign beepClockPinOe = beepOe_reg;
  assign irq = irq_reg;
endmodule : mpfc_misc_pin_function_control
`default_nettype wire

// ===== tb/mpfc_pin_model.sv
// Pin-side partner: interrupt, NMI and slave-select pins, oscillator waves.
// Assumes pinCmd comes from the bench; pins move on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module mpfc_pin_model (
  input wire logic ref_clk,
  input wire logic [6:0] pinCmd,
  output logic [4:0] extPins,
  output logic nmiPin,
  output logic ssPin,
  output logic auxOscHalf,
  output logic mainOscHalf
);
  logic [7:0] cnt = 8'h00;
  initial {ssPin, nmiPin, extPins} = 7'h7F;
  // Pins change away from the sampling edge, as asynchronous pins would.
  always @(negedge ref_clk) begin
    {ssPin, nmiPin, extPins} <= pinCmd;
    cnt <= cnt + 8'h01;
  end
  assign auxOscHalf = cnt[7];
  assign mainOscHalf = cnt[0];
endmodule : mpfc_pin_model
`default_nettype wire

// ===== tb/mpfc_misc_pin_function_control_chk.sv
// Checker bound to the pin function block.
// Assumes clkEn held high and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module mpfc_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic haltMode,
  input wire logic slaveSelectPinIn,
  input wire logic nmiEvent,
  input wire logic spiSlaveSelect,
  input wire logic slaveSelectPinFree,
  input wire logic auxClockPinOe,
  input wire logic beepClockPinOe
);
  logic [7:0] cfg2_reg, cfg2_next;
  logic nmiOn_reg, nmiOn_next;
  always_comb begin
    cfg2_next = cfg2_reg;
    nmiOn_next = nmiOn_reg;
    if (regWr && regAddr == mpfc_pkg::ADDR_CLKOUT_BEEP) cfg2_next = regWdata & 8'hF3;
    if (regWr && regAddr == mpfc_pkg::ADDR_SENSE_NMI) nmiOn_next = regWdata[0];
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg2_reg <= 8'h00;
      nmiOn_reg <= 1'b0;
    end else begin
      cfg2_reg <= cfg2_next;
      nmiOn_reg <= nmiOn_next;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not idle");
  a_read_value: assert property ($past(regRd) && $past(regAddr) == 8'h40
    |-> regRdata == $past(cfg2_reg)) else $error("clock-out register readback wrong");
  a_halt_quiet: assert property (haltMode [*2] |-> !auxClockPinOe && !beepClockPinOe)
    else $error("clock output driven in halt");
  a_ss_pin: assert property ((!slaveSelectPinFree && $stable(slaveSelectPinIn)) [*5]
    |-> spiSlaveSelect == slaveSelectPinIn) else $error("slave select not from pin");
  a_ss_internal: assert property ((cfg2_reg[1] && $stable(cfg2_reg)) [*3]
    |-> slaveSelectPinFree && spiSlaveSelect == cfg2_reg[0]) else $error("internal select wrong");
  a_nmi_off: assert property (!nmiOn_reg [*6] |-> !nmiEvent)
    else $error("event from disabled nmi");
  a_aux_on: assert property ((cfg2_reg[7] && !haltMode) [*3] |-> auxClockPinOe)
    else $error("aux clock-out not driven");
  a_beep_off: assert property ((cfg2_reg[6:4] == 3'h0) [*3] |-> !beepClockPinOe)
    else $error("beep pin driven in io mode");
  c_halt: cover property (haltMode && auxClockPinOe);
  c_nmi: cover property (nmiEvent);
  c_ss: cover property (slaveSelectPinFree && !spiSlaveSelect);
endmodule : mpfc_chk
bind mpfc_misc_pin_function_control mpfc_chk u_chk (.*);
`default_nettype wire

// ===== tb/test_misc_pin_function_control.sv
// Bench for the pin function block: registers, pins, interrupts, clock-outs.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_misc_pin_function_control;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic haltMode = 1'b0;
  logic [1:0] prio = 2'h3;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [6:0] pinCmd = 7'h7F;
  logic [7:0] regRdata;
  logic [4:0] extPins, extIrqEvent;
  logic nmiPin, ssPin, auxOsc, mainOsc, nmiEvent, spiSs, ssFree;
  logic auxOut, auxOe, beepOut, beepOe, irq;
  logic [31:0] seed = 32'h28;
  logic [7:0] m1 = 8'h00;
  int fails = 0;
  int num_checks = 0;
  int cnt [6];
  always #10 ref_clk = ~ref_clk;
  mpfc_pin_model pm (.ref_clk(ref_clk), .pinCmd(pinCmd), .extPins(extPins), .nmiPin(nmiPin),
    .ssPin(ssPin), .auxOscHalf(auxOsc), .mainOscHalf(mainOsc));
  mpfc_misc_pin_function_control uut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(1'b1),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .interruptPriorityLevel(prio), .haltMode(haltMode), .auxOscHalf(auxOsc),
    .mainOscHalf(mainOsc), .extIrqPortaLowPin(extPins[0]), .extIrqPortaHighPin(extPins[1]),
    .extIrqPortbPin(extPins[2]), .extIrqPortcPin(extPins[3]), .extIrqPortdPin(extPins[4]),
    .nmiPin(nmiPin), .slaveSelectPinIn(ssPin), .extIrqEvent(extIrqEvent), .nmiEvent(nmiEvent),
    .spiSlaveSelect(spiSs), .slaveSelectPinFree(ssFree), .auxClockPinOut(auxOut),
    .auxClockPinOe(auxOe), .beepClockPinOut(beepOut), .beepClockPinOe(beepOe), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] exp1(input logic [7:0] c, input logic [7:0] w,
                                      input logic [1:0] p);
    logic [7:0] n;
    n = w & 8'hF3;
    if (p != 2'h3) n[7:4] = c[7:4];
    if (c[0]) n[1] = c[1];
    return n;
  endfunction : exp1
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    tick(1);
    regWr <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    tick(1);
    regRd <= 1'b0;
    cmp(regRdata, e);
    tick(1);
  endtask : rd
  task automatic pulse(input logic [6:0] low);
    cnt = '{default: 0};
    for (int i = 0; i < 40; i++) begin
      pinCmd <= (i < 15) ? ~low : 7'h7F;
      tick(1);
      for (int b = 0; b < 5; b++) cnt[b] += extIrqEvent[b];
      cnt[5] += (i >= 15) & nmiEvent;
    end
  endtask : pulse
  initial begin
    logic [7:0] w;
    logic [1:0] code;
    int n;
    tick(4);
    arst_n <= 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      prio <= seed[9:8];
      w = seed[7:0];
      wr(8'h20, w);
      m1 = exp1(m1, w, seed[9:8]);
      rd(8'h20, m1);
      wr(8'h40, seed[23:16]);
      rd(8'h40, seed[23:16] & 8'hF3);
    end
    prio <= 2'h3;
    for (int k = 0; k < 4; k++) begin
      wr(8'h20, {2'(k), 2'(3 - k), 4'h0});
      pulse(7'h3F);
      for (int b = 0; b < 5; b++) begin
        code = (b % 2 == 1) ? 2'(3 - k) : 2'(k);
        if (code == 2'h0) cmp(32'(cnt[b] > 4), 32'h1);
        else cmp(cnt[b], (code == 2'h3) ? 32'h2 : 32'h1);
      end
      cmp(cnt[5], 32'h0);
    end
    wr(8'h20, 8'h03);
    pulse(7'h20);
    cmp(cnt[5], 32'h1);
    wr(8'h20, 8'h01);
    rd(8'h20, 8'h03);
    prio <= 2'h2;
    wr(8'h20, 8'hF0);
    rd(8'h20, 8'h02);
    pulse(7'h20);
    cmp(cnt[5], 32'h0);
    prio <= 2'h3;
    rd(8'h60, 8'h3F);
    wr(8'h61, 8'h20);
    tick(2);
    cmp(irq, 1'b1);
    wr(8'h60, 8'h20);
    tick(2);
    cmp(irq, 1'b0);
    rd(8'h60, 8'h1F);
    for (int j = 0; j < 8; j++) begin
      wr(8'h40, {1'b1, 3'(j), 4'h0});
      tick(3);
      cmp({auxOe, beepOe}, {1'b1, j != 0});
    end
    haltMode <= 1'b1;
    tick(3);
    cmp({auxOe, beepOe, auxOut, beepOut}, 4'h0);
    haltMode <= 1'b0;
    wr(8'h40, 8'h10);
    for (int p = 0; p < 2; p++) begin
      w[0] = beepOut;
      for (n = 0; n < 30000 && beepOut === w[0]; n++) tick(1);
    end
    cmp(n, 32'(mpfc_pkg::BEEP2K_HALF));
    if (n >= 30000) end_sim;
    pinCmd <= 7'h3F;
    wr(8'h40, 8'h00);
    tick(5);
    cmp({ssFree, spiSs}, 2'h0);
    wr(8'h40, 8'h03);
    tick(3);
    cmp({ssFree, spiSs}, 2'h3);
    end_sim;
  end
endmodule : test_misc_pin_function_control
`default_nettype wire
